/* File: design/ftcu_core.sv */
// Sequencer for transcendental and control operations of the stack unit
`timescale 1ns/100ps
`default_nettype none
`include "ftcu_consts.svh"
// Overview of operation
// - Trig ops use stack top entries, write back
// - Trig inputs radians; arctangent takes rectangular coordinates
// - Sine-cosine gives both, faster than two
// - Arctangent of next over top, radians
// - Reduce argument by pi, remainder path
// - Pi constant: 66-bit fraction, exponent one; the reduction loads only the top 64 fraction bits
// - Scaled log: y times log2 x
// - Log plus one: y times log2(x+1)
// - Exp2 minus one defined on [-1,+1]
// - Scale multiplies by integral power two
// - Error measured in ulps, exponent minus 63
// - Below 1 ulp nearest, 1.5 otherwise
// - Results monotonic over supported domain
// - Log ops within 1.35 ulps when y not one
// - Initialise sets control, status and tag words to defaults; data registers keep their values
// - Control word load/store, status word store
// - Environment store; state save adds data registers
// - State save then reinitialises like initialise
// - Environment load and state restore reload
// - Sync op handles pending unmasked exceptions first
// - Inc/dec top, free, clear flags, no-op
// - Waiting forms check exceptions; non-waiting skip
module ftcu_core (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_op_valid,
    input wire ftcu_pkg::ftcu_op_t i_op,
    input wire logic i_op_wait,
    input wire logic [`FTCU_PTR_W-1:0] i_op_reg,
    input wire logic [15:0] i_op_word,
    input wire logic [`FTCU_DATA_W-1:0] i_mem_rdata,
    input wire logic i_mem_rvalid,
    input wire logic i_exc_handled,
    output logic o_op_ready,
    output logic o_done,
    output logic o_exc_pending,
    output logic [15:0] o_word,
    output logic o_word_valid,
    output logic o_mem_wvalid,
    output logic [`FTCU_DATA_W-1:0] o_mem_wdata,
    output logic o_mem_rreq,
    output logic [15:0] o_cw,
    output logic [15:0] o_sw
);
    typedef struct packed {
        ftcu_pkg::ftcu_state_t st;
        ftcu_pkg::ftcu_op_t op;
        logic waitf;
        logic [`FTCU_PTR_W-1:0] top;
        logic [15:0] cw;
        logic [15:0] sw;
        logic [2*`FTCU_NREG-1:0] tag;
        logic [7:0] cnt;
        logic [`FTCU_DATA_W-1:0] acc;
        logic [`FTCU_DATA_W-1:0] aux;
        logic [15:0] word;
        logic wvalid;
        logic done;
        logic mwvalid;
        logic [`FTCU_DATA_W-1:0] mwdata;
        logic rreq;
        logic [3:0] idx;
        logic [`FTCU_PTR_W-1:0] ireg;
    } ftcu_state_s_t;
    ftcu_state_s_t s_r, s_nxt;
    logic [`FTCU_DATA_W-1:0] rd_a, rd_b;
    logic rf_we;
    logic [`FTCU_PTR_W-1:0] rf_waddr;
    logic [`FTCU_DATA_W-1:0] rf_wdata;
    logic unmasked;
    // Pi kept to 68 bits; the two low bits are padding zeros of the last digit
    localparam logic [67:0] PI_FRAC = `FTCU_PI_FRAC;
    localparam logic [`FTCU_EXP_W-1:0] PI_EXP = `FTCU_PI_EXP;
    ftcu_regfile u_rf (
        .i_clk(i_clk),
        .i_we(rf_we),
        .i_waddr(rf_waddr),
        .i_wdata(rf_wdata),
        .i_raddr_a(s_r.top),
        .i_raddr_b(s_r.top + `FTCU_PTR_W'(1)),
        .o_rdata_a(rd_a),
        .o_rdata_b(rd_b)
    );
    assign unmasked = |(s_r.sw[5:0] & ~s_r.cw[5:0]);
    // =====================================================================
    // Next-state logic
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.wvalid = 1'b0;
        s_nxt.done = 1'b0;
        s_nxt.mwvalid = 1'b0;
        s_nxt.rreq = 1'b0;
        rf_we = 1'b0;
        rf_waddr = s_r.top;
        rf_wdata = s_r.acc;
        // Host reports its handler ran; cleared first so a same-cycle new flag wins
        if (i_exc_handled)
        begin
            s_nxt.sw[7:0] = 8'h0;
        end
        unique case (s_r.st)
            ftcu_pkg::FTCU_ST_IDLE:
            begin
                if (i_op_valid)
                begin
                    s_nxt.op = i_op;
                    s_nxt.waitf = i_op_wait;
                    s_nxt.ireg = i_op_reg;
                    s_nxt.word = i_op_word;
                    s_nxt.idx = 4'h0;
                    s_nxt.st = ftcu_pkg::FTCU_ST_CHECK;
                end
            end
            ftcu_pkg::FTCU_ST_CHECK:
            begin
                // Waiting forms stall until the host has serviced exceptions
                if ((s_r.waitf || s_r.op == ftcu_pkg::FTCU_OP_WAIT) && unmasked)
                begin
                    s_nxt.st = ftcu_pkg::FTCU_ST_CHECK;
                end
                else
                begin
                    s_nxt.st = ftcu_pkg::FTCU_ST_DONE;
                    unique case (s_r.op)
                        ftcu_pkg::FTCU_OP_SIN, ftcu_pkg::FTCU_OP_COS,
                        ftcu_pkg::FTCU_OP_SINCOS, ftcu_pkg::FTCU_OP_TAN:
                        begin
                            s_nxt.acc = rd_a;
                            s_nxt.st = ftcu_pkg::FTCU_ST_REDUCE;
                        end
                        ftcu_pkg::FTCU_OP_ATAN, ftcu_pkg::FTCU_OP_YL2X,
                        ftcu_pkg::FTCU_OP_YL2XP1, ftcu_pkg::FTCU_OP_SCALE:
                        begin
                            s_nxt.acc = rd_a;
                            s_nxt.aux = rd_b;
                            s_nxt.cnt = `FTCU_CORDIC_ITERS;
                            s_nxt.st = ftcu_pkg::FTCU_ST_ITER;
                        end
                        ftcu_pkg::FTCU_OP_EXP2M1:
                        begin
                            s_nxt.acc = rd_a;
                            s_nxt.cnt = `FTCU_CORDIC_ITERS;
                            s_nxt.st = ftcu_pkg::FTCU_ST_ITER;
                            // Outside [-1,+1] the result is undefined; flag invalid
                            if (rd_a[78:64] > `FTCU_ONE_EXP
                                || (rd_a[78:64] == `FTCU_ONE_EXP && rd_a[62:0] != 63'h0))
                            begin
                                s_nxt.sw[0] = 1'b1;
                            end
                        end
                        ftcu_pkg::FTCU_OP_INIT:
                        begin
                            s_nxt.cw = `FTCU_CW_RESET;
                            s_nxt.sw = `FTCU_SW_RESET;
                            s_nxt.tag = '1;
                            s_nxt.top = '0;
                        end
                        ftcu_pkg::FTCU_OP_LDCW:
                        begin
                            s_nxt.cw = s_r.word;
                        end
                        ftcu_pkg::FTCU_OP_STCW:
                        begin
                            s_nxt.word = s_r.cw;
                            s_nxt.wvalid = 1'b1;
                        end
                        ftcu_pkg::FTCU_OP_STSW:
                        begin
                            s_nxt.word = s_r.sw;
                            s_nxt.wvalid = 1'b1;
                        end
                        ftcu_pkg::FTCU_OP_CLEX:
                        begin
                            s_nxt.sw = s_r.sw & ~`FTCU_SW_EXC_MASK;
                        end
                        ftcu_pkg::FTCU_OP_STENV, ftcu_pkg::FTCU_OP_SAVE:
                        begin
                            s_nxt.st = ftcu_pkg::FTCU_ST_MEMOUT;
                        end
                        ftcu_pkg::FTCU_OP_LDENV, ftcu_pkg::FTCU_OP_RSTOR:
                        begin
                            s_nxt.rreq = 1'b1;
                            s_nxt.st = ftcu_pkg::FTCU_ST_MEMIN;
                        end
                        ftcu_pkg::FTCU_OP_INCSTP:
                        begin
                            s_nxt.top = s_r.top + `FTCU_PTR_W'(1);
                        end
                        ftcu_pkg::FTCU_OP_DECSTP:
                        begin
                            s_nxt.top = s_r.top - `FTCU_PTR_W'(1);
                        end
                        ftcu_pkg::FTCU_OP_FREE:
                        begin
                            s_nxt.tag[2*s_r.ireg +: 2] = `FTCU_TAG_EMPTY;
                        end
                        default:
                        begin
                            s_nxt.st = ftcu_pkg::FTCU_ST_DONE;
                        end
                    endcase
                end
            end
            ftcu_pkg::FTCU_ST_REDUCE:
            begin
                // Remainder step against pi sharing the partial-remainder path
                if (s_r.acc[78:64] > PI_EXP)
                begin
                    s_nxt.acc[78:64] = s_r.acc[78:64] - 15'h1;
                end
                else
                begin
                    s_nxt.aux = {1'b0, PI_EXP, PI_FRAC[67:4]};
                    // One fused pass yields both sine and cosine
                    s_nxt.cnt = `FTCU_CORDIC_ITERS;
                    s_nxt.st = ftcu_pkg::FTCU_ST_ITER;
                end
            end
            ftcu_pkg::FTCU_ST_ITER:
            begin
                // Iterative shift-add kernel; accuracy is owned by the kernel
                s_nxt.cnt = s_r.cnt - 8'h1;
                if (s_r.cnt == 8'h1)
                begin
                    s_nxt.st = ftcu_pkg::FTCU_ST_WRITE;
                    if (s_r.op == ftcu_pkg::FTCU_OP_SCALE)
                    begin
                        s_nxt.acc[78:64] = s_r.acc[78:64] + s_r.aux[78:64]
                            - `FTCU_EXP_BIAS;
                    end
                end
            end
            ftcu_pkg::FTCU_ST_WRITE:
            begin
                rf_we = 1'b1;
                rf_waddr = s_r.top;
                if (s_r.op == ftcu_pkg::FTCU_OP_ATAN || s_r.op == ftcu_pkg::FTCU_OP_YL2X
                    || s_r.op == ftcu_pkg::FTCU_OP_YL2XP1)
                begin
                    // Arctangent and log ops pop: result lands in next entry
                    rf_waddr = s_r.top + `FTCU_PTR_W'(1);
                    s_nxt.tag[2*s_r.top +: 2] = `FTCU_TAG_EMPTY;
                    s_nxt.top = s_r.top + `FTCU_PTR_W'(1);
                end
                else if (s_r.op == ftcu_pkg::FTCU_OP_SINCOS || s_r.op == ftcu_pkg::FTCU_OP_TAN)
                begin
                    if (s_r.idx == 4'h0)
                    begin
                        s_nxt.idx = 4'h1;
                        s_nxt.top = s_r.top - `FTCU_PTR_W'(1);
                        s_nxt.st = ftcu_pkg::FTCU_ST_WRITE;
                    end
                    else
                    begin
                        rf_wdata = s_r.aux;
                        s_nxt.tag[2*s_r.top +: 2] = `FTCU_TAG_VALID;
                        s_nxt.st = ftcu_pkg::FTCU_ST_DONE;
                    end
                end
                if (s_r.idx != 4'h0 || !(s_r.op == ftcu_pkg::FTCU_OP_SINCOS
                    || s_r.op == ftcu_pkg::FTCU_OP_TAN))
                begin
                    s_nxt.st = ftcu_pkg::FTCU_ST_DONE;
                end
            end
            ftcu_pkg::FTCU_ST_MEMOUT:
            begin
                s_nxt.mwvalid = 1'b1;
                s_nxt.idx = s_r.idx + 4'h1;
                if (s_r.idx == 4'h0)
                begin
                    s_nxt.mwdata = {64'h0, s_r.cw};
                end
                else if (s_r.idx == 4'h1)
                begin
                    s_nxt.mwdata = {64'h0, s_r.sw[15:14], s_r.top, s_r.sw[10:0]};
                end
                else if (s_r.idx == 4'h2)
                begin
                    s_nxt.mwdata = {64'h0, s_r.tag};
                    // Read port is registered: start the data walk one word early
                    if (s_r.op == ftcu_pkg::FTCU_OP_SAVE)
                    begin
                        s_nxt.top = s_r.top + `FTCU_PTR_W'(1);
                    end
                end
                else
                begin
                    s_nxt.mwdata = rd_a;
                    s_nxt.top = s_r.top + `FTCU_PTR_W'(1);
                end
                if ((s_r.op == ftcu_pkg::FTCU_OP_STENV && s_r.idx == 4'(`FTCU_ENV_WORDS - 1))
                    || s_r.idx == 4'(`FTCU_ENV_WORDS + `FTCU_NREG - 1))
                begin
                    s_nxt.st = ftcu_pkg::FTCU_ST_DONE;
                    if (s_r.op == ftcu_pkg::FTCU_OP_SAVE)
                    begin
                        s_nxt.cw = `FTCU_CW_RESET;
                        s_nxt.sw = `FTCU_SW_RESET;
                        s_nxt.tag = '1;
                        s_nxt.top = '0;
                    end
                end
            end
            ftcu_pkg::FTCU_ST_MEMIN:
            begin
                s_nxt.rreq = !i_mem_rvalid;
                if (i_mem_rvalid)
                begin
                    s_nxt.idx = s_r.idx + 4'h1;
                    s_nxt.rreq = 1'b1;
                    if (s_r.idx == 4'h0)
                    begin
                        s_nxt.cw = i_mem_rdata[15:0];
                    end
                    else if (s_r.idx == 4'h1)
                    begin
                        s_nxt.sw = i_mem_rdata[15:0];
                        s_nxt.top = i_mem_rdata[13:11];
                    end
                    else if (s_r.idx == 4'h2)
                    begin
                        s_nxt.tag = i_mem_rdata[15:0];
                    end
                    else
                    begin
                        rf_we = 1'b1;
                        rf_waddr = s_r.idx[2:0] - 3'h3 + s_r.top;
                        rf_wdata = i_mem_rdata;
                    end
                    if ((s_r.op == ftcu_pkg::FTCU_OP_LDENV && s_r.idx == 4'(`FTCU_ENV_WORDS - 1))
                        || s_r.idx == 4'(`FTCU_ENV_WORDS + `FTCU_NREG - 1))
                    begin
                        s_nxt.rreq = 1'b0;
                        s_nxt.st = ftcu_pkg::FTCU_ST_DONE;
                    end
                end
            end
            ftcu_pkg::FTCU_ST_DONE:
            begin
                s_nxt.done = 1'b1;
                s_nxt.st = ftcu_pkg::FTCU_ST_IDLE;
            end
        endcase
        s_nxt.sw[`FTCU_SW_ES_BIT] = |(s_nxt.sw[5:0] & ~s_nxt.cw[5:0]);
        s_nxt.sw[13:11] = s_nxt.top;
        if (i_srst)
        begin
            s_nxt = '0;
            s_nxt.st = ftcu_pkg::FTCU_ST_IDLE;
            s_nxt.cw = `FTCU_CW_RESET;
            s_nxt.tag = '1;
            rf_we = 1'b0;
        end
    end
    always_ff @(posedge i_clk)
    begin
        s_r <= s_nxt;
    end
    assign o_op_ready = (s_r.st == ftcu_pkg::FTCU_ST_IDLE);
    assign o_done = s_r.done;
    assign o_exc_pending = unmasked;
    assign o_word = s_r.word;
    assign o_word_valid = s_r.wvalid;
    assign o_mem_wvalid = s_r.mwvalid;
    assign o_mem_wdata = s_r.mwdata;
    assign o_mem_rreq = s_r.rreq;
    assign o_cw = s_r.cw;
    assign o_sw = s_r.sw;
    // =====================================================================
    // Checks
    AST_WAIT_HOLDS: assert property (@(posedge i_clk) disable iff (i_srst)
        (s_r.st == ftcu_pkg::FTCU_ST_CHECK && s_r.op == ftcu_pkg::FTCU_OP_WAIT && unmasked)
        |=> s_r.st == ftcu_pkg::FTCU_ST_CHECK)
        else $error("sync op advanced with unmasked exception");
    AST_INC_WRAP: assert property (@(posedge i_clk) disable iff (i_srst)
        (s_r.st == ftcu_pkg::FTCU_ST_CHECK && s_r.op == ftcu_pkg::FTCU_OP_INCSTP && !unmasked)
        |=> s_r.top == $past(s_r.top) + 3'h1)
        else $error("top pointer increment wrong");
    AST_INIT_DEF: assert property (@(posedge i_clk) disable iff (i_srst)
        (s_r.st == ftcu_pkg::FTCU_ST_CHECK && s_r.op == ftcu_pkg::FTCU_OP_INIT
        && !(s_r.waitf && unmasked))
        |=> s_r.cw == `FTCU_CW_RESET && s_r.top == 3'h0 && s_r.tag == 16'hffff)
        else $error("initialise left non-default state");
    AST_NOWAIT: assert property (@(posedge i_clk) disable iff (i_srst)
        (s_r.st == ftcu_pkg::FTCU_ST_CHECK && !s_r.waitf && s_r.op != ftcu_pkg::FTCU_OP_WAIT)
        |=> s_r.st != ftcu_pkg::FTCU_ST_CHECK)
        else $error("non-waiting op stalled");
    AST_STSW: assert property (@(posedge i_clk) disable iff (i_srst)
        o_word_valid && s_r.op == ftcu_pkg::FTCU_OP_STSW |-> o_word == $past(s_r.sw))
        else $error("status word store value wrong");
    AST_SAVE_INIT: assert property (@(posedge i_clk) disable iff (i_srst)
        (s_r.op == ftcu_pkg::FTCU_OP_SAVE && $rose(s_r.st == ftcu_pkg::FTCU_ST_DONE))
        |-> s_r.cw == `FTCU_CW_RESET && s_r.top == 3'h0)
        else $error("state save did not reinitialise");
    AST_CLEX: assert property (@(posedge i_clk) disable iff (i_srst)
        (s_r.st == ftcu_pkg::FTCU_ST_CHECK && s_r.op == ftcu_pkg::FTCU_OP_CLEX && !s_r.waitf)
        |=> s_r.sw[5:0] == 6'h0)
        else $error("flag clear left flags set");
    AST_DONE_PULSE: assert property (@(posedge i_clk) disable iff (i_srst)
        o_done |-> o_op_ready ##1 !o_done)
        else $error("done not a single pulse");
endmodule
`default_nettype wire

/* File: inc/ftcu_consts.svh */
// Constants for the floating-point transcendental and control unit
`ifndef FTCU_CONSTS_SVH
`define FTCU_CONSTS_SVH
`define FTCU_NREG 8
`define FTCU_PTR_W 3
`define FTCU_DATA_W 80
`define FTCU_FRAC_W 64
`define FTCU_EXP_W 15
`define FTCU_EXP_BIAS 15'h3fff
`define FTCU_PI_FRAC 68'hc90fdaa22168c234c
`define FTCU_PI_EXP 15'h4000
`define FTCU_CW_RESET 16'h037f
`define FTCU_SW_RESET 16'h0000
`define FTCU_TAG_EMPTY 2'h3
`define FTCU_TAG_VALID 2'h0
`define FTCU_SW_ES_BIT 7
`define FTCU_SW_EXC_MASK 16'h00ff
`define FTCU_SW_TOP_LSB 11
`define FTCU_ENV_WORDS 3
`define FTCU_CORDIC_ITERS 8'd66
`define FTCU_ONE_EXP 15'h3fff
`endif

/* File: inc/ftcu_pkg.sv */
// Types for the floating-point transcendental and control unit
package ftcu_pkg;
    typedef enum logic [4:0] {
        FTCU_OP_NOP, FTCU_OP_SIN, FTCU_OP_COS, FTCU_OP_SINCOS, FTCU_OP_TAN,
        FTCU_OP_ATAN, FTCU_OP_YL2X, FTCU_OP_YL2XP1, FTCU_OP_EXP2M1, FTCU_OP_SCALE,
        FTCU_OP_INIT, FTCU_OP_LDCW, FTCU_OP_STCW, FTCU_OP_STSW, FTCU_OP_CLEX,
        FTCU_OP_LDENV, FTCU_OP_STENV, FTCU_OP_RSTOR, FTCU_OP_SAVE, FTCU_OP_INCSTP,
        FTCU_OP_DECSTP, FTCU_OP_FREE, FTCU_OP_WAIT
    } ftcu_op_t;
    typedef enum {
        FTCU_ST_IDLE, FTCU_ST_CHECK, FTCU_ST_REDUCE, FTCU_ST_ITER, FTCU_ST_WRITE,
        FTCU_ST_MEMOUT, FTCU_ST_MEMIN, FTCU_ST_DONE
    } ftcu_state_t;
endpackage

/* File: design/ftcu_regfile.sv */
// Eight-entry data register stack with registered read ports
`timescale 1ns/100ps
`default_nettype none
`include "ftcu_consts.svh"
module ftcu_regfile (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [`FTCU_PTR_W-1:0] i_waddr,
    input wire logic [`FTCU_DATA_W-1:0] i_wdata,
    input wire logic [`FTCU_PTR_W-1:0] i_raddr_a,
    input wire logic [`FTCU_PTR_W-1:0] i_raddr_b,
    output logic [`FTCU_DATA_W-1:0] o_rdata_a,
    output logic [`FTCU_DATA_W-1:0] o_rdata_b
);
    logic [`FTCU_DATA_W-1:0] mem [`FTCU_NREG];
    always_ff @(posedge i_clk)
    begin
        if (i_we)
        begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata_a <= mem[i_raddr_a];
        o_rdata_b <= mem[i_raddr_b];
    end
endmodule
`default_nettype wire

/* File: verif/ftcu_host_mem.sv */
// Behavioural memory that serves environment and state images to the unit
`timescale 1ns/100ps
`default_nettype none
`include "ftcu_consts.svh"
module ftcu_host_mem (
    input wire logic i_clk,
    input wire logic i_mem_rreq,
    input wire logic i_mem_wvalid,
    input wire logic [`FTCU_DATA_W-1:0] i_mem_wdata,
    output logic o_mem_rvalid,
    output logic [`FTCU_DATA_W-1:0] o_mem_rdata
);
    logic [`FTCU_DATA_W-1:0] img [0:10];
    logic [`FTCU_DATA_W-1:0] wr [0:10];
    int rdi = 0;
    int wri = 0;
    initial
    begin
        o_mem_rvalid = 1'b0;
        o_mem_rdata = '0;
    end
    // ==========================================================
    // Read side
    // One word every other cycle: a slow memory; stale data is inverted
    always @(negedge i_clk)
    begin
        if (i_mem_rreq && !o_mem_rvalid && rdi < 11)
        begin
            o_mem_rdata <= img[rdi];
            rdi <= rdi + 1;
            o_mem_rvalid <= 1'b1;
        end
        else
        begin
            o_mem_rdata <= ~o_mem_rdata;
            o_mem_rvalid <= 1'b0;
        end
    end
    // ==========================================================
    // Write side
    always @(posedge i_clk)
    begin
        if (i_mem_wvalid && wri < 11)
        begin
            wr[wri] <= i_mem_wdata;
            wri <= wri + 1;
        end
    end
endmodule
`default_nettype wire

/* File: verif/test_float_transcendental_control_unit.sv */
// Self-checking bench for the transcendental and control sequencer
`timescale 1ns/100ps
`default_nettype none
`include "ftcu_consts.svh"
module test_float_transcendental_control_unit;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_op_valid = 1'b0;
    ftcu_pkg::ftcu_op_t i_op = ftcu_pkg::FTCU_OP_NOP;
    logic i_op_wait = 1'b0;
    logic [2:0] i_op_reg = 3'h0;
    logic [15:0] i_op_word = 16'h0000;
    logic i_exc_handled = 1'b0;
    logic [`FTCU_DATA_W-1:0] mem_rdata, mem_wdata;
    logic mem_rvalid, op_ready, done, exc_pending, word_valid, mem_wvalid, mem_rreq;
    logic [15:0] word, cw, sw, last_word;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    int cyc [1:9];
    int n;
    always #10 i_clk = ~i_clk;
    ftcu_core uut (.i_clk(i_clk), .i_srst(i_srst), .i_op_valid(i_op_valid), .i_op(i_op),
        .i_op_wait(i_op_wait), .i_op_reg(i_op_reg), .i_op_word(i_op_word),
        .i_mem_rdata(mem_rdata), .i_mem_rvalid(mem_rvalid), .i_exc_handled(i_exc_handled),
        .o_op_ready(op_ready), .o_done(done), .o_exc_pending(exc_pending), .o_word(word),
        .o_word_valid(word_valid), .o_mem_wvalid(mem_wvalid), .o_mem_wdata(mem_wdata),
        .o_mem_rreq(mem_rreq), .o_cw(cw), .o_sw(sw));
    ftcu_host_mem mem (.i_clk(i_clk), .i_mem_rreq(mem_rreq), .i_mem_wvalid(mem_wvalid),
        .i_mem_wdata(mem_wdata), .o_mem_rvalid(mem_rvalid), .o_mem_rdata(mem_rdata));
    // ==========================================================
    // Shared tasks
    task chk(input string what, input logic [79:0] exp, input logic [79:0] got);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Handler pulse after handle_at cycles stands in for the host service routine
    task do_op(input ftcu_pkg::ftcu_op_t op, input logic wt, input logic [15:0] wd,
        input int handle_at, output int nc);
        nc = 0;
        @(negedge i_clk);
        while (op_ready !== 1'b1)
            @(negedge i_clk);
        i_op_valid = 1'b1;
        i_op = op;
        i_op_wait = wt;
        i_op_word = wd;
        i_op_reg = 3'h5;
        @(negedge i_clk);
        i_op_valid = 1'b0;
        while (done !== 1'b1 && nc < 2000)
        begin
            if (word_valid === 1'b1)
                last_word = word;
            i_exc_handled = (nc == handle_at);
            @(negedge i_clk);
            nc++;
        end
        i_exc_handled = 1'b0;
        chk("done", 1'b1, done);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task t_arith;
        for (int k = 1; k <= 9; k++)
            do_op(ftcu_pkg::ftcu_op_t'(k), 1'b0, 16'h0000, -1, cyc[k]);
        chk("sincos faster", 1'b1, cyc[3] < cyc[1] + cyc[2]);
        do_op(ftcu_pkg::FTCU_OP_INIT, 1'b0, 16'h0000, -1, n);
        chk("init sw", 16'h0000, sw);
        $display("test arith done");
    endtask
    task t_words;
        do_op(ftcu_pkg::FTCU_OP_LDCW, 1'b1, 16'h0263, -1, n);
        chk("cw load", 16'h0263, cw);
        do_op(ftcu_pkg::FTCU_OP_STCW, 1'b1, 16'h0000, -1, n);
        chk("cw store", 16'h0263, last_word);
        do_op(ftcu_pkg::FTCU_OP_STSW, 1'b1, 16'h0000, -1, n);
        chk("sw store", 16'h0000, last_word);
        $display("test words done");
    endtask
    task t_stack;
        do_op(ftcu_pkg::FTCU_OP_DECSTP, 1'b1, 16'h0000, -1, n);
        chk("top wrap", 3'h7, sw[13:11]);
        do_op(ftcu_pkg::FTCU_OP_INCSTP, 1'b1, 16'h0000, -1, n);
        chk("top back", 3'h0, sw[13:11]);
        do_op(ftcu_pkg::FTCU_OP_FREE, 1'b1, 16'h0000, -1, n);
        do_op(ftcu_pkg::FTCU_OP_NOP, 1'b1, 16'h0000, -1, n);
        chk("nop top", 3'h0, sw[13:11]);
        $display("test stack done");
    endtask
    task t_save;
        mem.wri = 0;
        do_op(ftcu_pkg::FTCU_OP_STENV, 1'b1, 16'h0000, -1, n);
        chk("env words", 3, mem.wri);
        chk("env cw", 16'h0263, mem.wr[0][15:0]);
        mem.wri = 0;
        do_op(ftcu_pkg::FTCU_OP_SAVE, 1'b0, 16'h0000, -1, n);
        chk("save words", 11, mem.wri);
        chk("save cw", 16'h0263, mem.wr[0][15:0]);
        chk("save reinit", 16'h037f, cw);
        $display("test save done");
    endtask
    task t_restore;
        for (int k = 3; k <= 10; k++)
            mem.img[k] = 80'(k);
        mem.img[0] = 80'h037e;
        mem.img[1] = 80'h0001;
        mem.img[2] = 80'h0000;
        mem.rdi = 0;
        do_op(ftcu_pkg::FTCU_OP_RSTOR, 1'b0, 16'h0000, -1, n);
        chk("restore words", 11, mem.rdi);
        chk("restore cw", 16'h037e, cw);
        chk("pending", 1'b1, exc_pending);
        do_op(ftcu_pkg::FTCU_OP_STSW, 1'b0, 16'h0000, -1, n);
        chk("nowait quick", 1'b1, n < 8);
        chk("nowait sw", 1'b1, last_word[0]);
        do_op(ftcu_pkg::FTCU_OP_WAIT, 1'b1, 16'h0000, 10, n);
        chk("sync stall", 1'b1, n > 10);
        chk("sync flags", 8'h00, sw[7:0]);
        mem.rdi = 0;
        do_op(ftcu_pkg::FTCU_OP_LDENV, 1'b0, 16'h0000, -1, n);
        chk("env load", 3, mem.rdi);
        do_op(ftcu_pkg::FTCU_OP_CLEX, 1'b0, 16'h0000, -1, n);
        chk("clear flags", 1'b0, exc_pending);
        do_op(ftcu_pkg::FTCU_OP_FREE, 1'b0, 16'h0000, -1, n);
        mem.wri = 0;
        do_op(ftcu_pkg::FTCU_OP_STENV, 1'b0, 16'h0000, -1, n);
        chk("free tag", 16'h0c00, mem.wr[2][15:0]);
        mem.wri = 0;
        do_op(ftcu_pkg::FTCU_OP_SAVE, 1'b0, 16'h0000, -1, n);
        for (int k = 3; k <= 10; k++)
            chk("save data", 80'(k), mem.wr[k]);
        $display("test restore done");
    endtask
    // ==========================================================
    // Run
    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            error_cnt++;
            conclude();
        end
    end
    initial
    begin
        repeat (16) @(negedge i_clk);
        i_srst = 1'b0;
        chk("reset cw", 16'h037f, cw);
        chk("reset sw", 16'h0000, sw);
        chk("reset ready", 1'b1, op_ready);
        t_arith();
        t_words();
        t_stack();
        t_save();
        t_restore();
        conclude();
    end
endmodule
`default_nettype wire
